// >>> design/bfpcf_port_control.sv
// Two-port control and flag logic around a forward and a return queue
`timescale 1ns/1ps
// How it works
// - Port B transfers timed by port B clock
// - Port B flags change on port B edges
// - Port A access needs chip select low
// - Port A bus released while select high
// - Port B access needs chip select low
// - Port B bus released while select high
// - Port A access needs enable high
// - Port B access needs enable high
// - Standard: port A shows return queue empty
// - Fall-through: port A shows word ready
// - Standard: port B shows forward queue empty
// - Fall-through: port B shows word ready
// - Standard: port A shows forward queue full
// - Fall-through: port A shows space to write
// - Standard: port B shows return queue full
// - Fall-through: port B shows space to write
// - Port A flags change on port A edges
// - Timing select latched at reset, kept static
// - Port A transfers timed by port A clock
module bfpcf_port_control
    import bfpcf_pkg::*;
#(
    parameter int WIDTH = PORT_WIDTH,
    parameter int ADDR_BITS = QUEUE_ADDR_BITS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic portBClock,
    input wire logic fallThroughSelect,
    input wire logic portASelectN,
    input wire logic portAEnable,
    input wire logic portAWrite,
    input wire logic [WIDTH-1:0] portADataIn,
    output logic [WIDTH-1:0] portADataOut,
    output logic portADataOeN,
    output logic portAFullInputReady,
    output logic portAEmptyOutputReady,
    input wire logic portBSelectN,
    input wire logic portBEnable,
    input wire logic portBWrite,
    input wire logic [WIDTH-1:0] portBDataIn,
    output logic [WIDTH-1:0] portBDataOut,
    output logic portBDataOeN,
    output logic portBFullInputReady,
    output logic portBEmptyOutputReady
);
    // Port A side state, on clk
    typedef struct packed {
        logic modeSync1;
        logic modeSync2;
        logic modeStd;
        logic [WIDTH-1:0] dataOut;
        logic outValid;
    } bfpcf_a_state_type;

    // Port B side state, on portBClock
    typedef struct packed {
        logic rstSync1;
        logic rstSync2;
        logic modeSync1;
        logic modeSync2;
        logic [WIDTH-1:0] dataOut;
        logic outValid;
    } bfpcf_b_state_type;

    // State registers and next values
    bfpcf_a_state_type a_q, a_d;
    bfpcf_b_state_type b_q, b_d;

    // Port B domain reset, standard mode copy
    logic rstB;
    logic modeStdB;
    // Access qualifiers
    logic accessA, readA, writeA;
    logic accessB, readB, writeB;
    // Queue handshakes
    logic fwdPush, fwdFull, fwdPop, fwdEmpty;
    logic retPush, retFull, retPop, retEmpty;
    logic [WIDTH-1:0] fwdHead, retHead;
    // Output stage step results
    logic [1:0] stepA, stepB;

    // Output stage: {load, validNext} for one port
    function automatic logic [1:0] stageStep(input logic std, input logic rd,
                                             input logic empty, input logic valid);
        logic load;
        load = 1'h0;
        if (std) begin
            load = rd && !empty;
            stageStep = {load, 1'h0};
        end else begin
            load = !empty && (!valid || rd);
            stageStep = {load, load || (valid && !rd)};
        end
    endfunction

    assign rstB = b_q.rstSync2;
    assign modeStdB = b_q.modeSync2;

    // access on select low and enable high
    assign accessA = !portASelectN && portAEnable;
    // direction input picks read or write
    assign readA = accessA && !portAWrite;
    assign writeA = accessA && portAWrite;
    assign accessB = !portBSelectN && portBEnable;
    assign readB = accessB && !portBWrite;
    assign writeB = accessB && portBWrite;

    // Writes land in the queue only when space exists
    assign fwdPush = writeA && !fwdFull;
    assign retPush = writeB && !retFull;
    assign stepA = stageStep(a_q.modeStd, readA, retEmpty, a_q.outValid);
    assign stepB = stageStep(modeStdB, readB, fwdEmpty, b_q.outValid);
    assign retPop = stepA[1];
    assign fwdPop = stepB[1];

    // Forward queue, port A to port B
    bfpcf_async_queue #(
        .WIDTH(WIDTH),
        .ADDR_BITS(ADDR_BITS)
    ) forwardQueue (
        .wrClk(clk),
        .wrRst(rst),
        .wrPush(fwdPush),
        .wrData(portADataIn),
        .wrFull(fwdFull),
        .rdClk(portBClock),
        .rdRst(rstB),
        .rdPop(fwdPop),
        .rdData(fwdHead),
        .rdEmpty(fwdEmpty)
    );

    // Return queue, port B to port A
    bfpcf_async_queue #(
        .WIDTH(WIDTH),
        .ADDR_BITS(ADDR_BITS)
    ) returnQueue (
        .wrClk(portBClock),
        .wrRst(rstB),
        .wrPush(retPush),
        .wrData(portBDataIn),
        .wrFull(retFull),
        .rdClk(clk),
        .rdRst(rst),
        .rdPop(retPop),
        .rdData(retHead),
        .rdEmpty(retEmpty)
    );

    // Port A next state
    always_comb begin
        a_d = a_q;
        // Timing select pin synchroniser
        a_d.modeSync1 = fallThroughSelect;
        a_d.modeSync2 = a_q.modeSync1;
        // output register loads on port A edges
        if (stepA[1]) begin
            a_d.dataOut = retHead;
        end
        a_d.outValid = stepA[0];
        if (rst) begin
            // mode follows the pin while reset holds
            a_d.modeStd = (a_q.modeSync2 == MODE_STD_LEVEL);
            a_d.dataOut = DATA_RESET;
            a_d.outValid = VALID_RESET;
        end
    end

    // Port A registers
    always_ff @(posedge clk) begin
        a_q <= a_d;
    end

    // Port B next state
    always_comb begin
        b_d = b_q;
        // Reset and mode level crossings
        b_d.rstSync1 = rst;
        b_d.rstSync2 = b_q.rstSync1;
        b_d.modeSync1 = a_q.modeStd;
        b_d.modeSync2 = b_q.modeSync1;
        // output register loads on port B edges
        if (stepB[1]) begin
            b_d.dataOut = fwdHead;
        end
        b_d.outValid = stepB[0];
        if (rstB) begin
            b_d.dataOut = DATA_RESET;
            b_d.outValid = VALID_RESET;
        end
    end

    // Port B registers
    always_ff @(posedge portBClock) begin
        b_q <= b_d;
    end

    // Data outputs from flip-flops
    assign portADataOut = a_q.dataOut;
    assign portBDataOut = b_q.dataOut;
    // port A bus released while select high
    assign portADataOeN = portASelectN;
    // port B bus released while select high
    assign portBDataOeN = portBSelectN;

    // port A empty or ready from clk registers
    assign portAEmptyOutputReady = a_q.modeStd ? retEmpty : a_q.outValid;
    // port A full or input ready
    assign portAFullInputReady = a_q.modeStd ? fwdFull : !fwdFull;
    // port B empty or ready from portBClock registers
    assign portBEmptyOutputReady = modeStdB ? fwdEmpty : b_q.outValid;
    // port B full or input ready
    assign portBFullInputReady = modeStdB ? retFull : !retFull;

    // Port A checks, fall-through loads show up as a rising output ready
    idle_a_data_a: assert property (@(posedge clk) disable iff (rst)
        (portASelectN || !portAEnable) |=> ($stable(portADataOut) || $rose(a_q.outValid)))
        else $error("port A data changed without access");

    release_a_bus_a: assert property (@(posedge clk) disable iff (rst)
        portASelectN |-> portADataOeN)
        else $error("port A bus driven while deselected");

    no_enable_a_a: assert property (@(posedge clk) disable iff (rst)
        (!portAEnable && !portASelectN) |=> ($stable(portADataOut) || $rose(a_q.outValid)))
        else $error("port A transfer without enable");

    std_empty_a_a: assert property (@(posedge clk) disable iff (rst)
        (a_q.modeStd && readA && portAEmptyOutputReady) |=> $stable(portADataOut))
        else $error("port A read while empty changed data");

    fall_through_select_ready_a_a: assert property (@(posedge clk) disable iff (rst)
        (!a_q.modeStd && !retEmpty && !portAEmptyOutputReady) |=> portAEmptyOutputReady)
        else $error("port A word not presented");

    std_full_a_a: assert property (@(posedge clk) disable iff (rst)
        (a_q.modeStd && portAFullInputReady && writeA) |=> $stable(forwardQueue.wr_q.bin))
        else $error("port A write taken while full");

    fall_through_select_space_a_a: assert property (@(posedge clk) disable iff (rst)
        (!a_q.modeStd && !portAFullInputReady && writeA) |=> $stable(forwardQueue.wr_q.bin))
        else $error("port A write taken while not ready");

    mode_static_a: assert property (@(posedge clk)
        (!rst && !$past(rst)) |-> $stable(a_q.modeStd))
        else $error("timing mode changed after reset");

    // Port B checks, fall-through loads show up as a rising output ready
    idle_b_data_a: assert property (@(posedge portBClock) disable iff (rstB)
        (portBSelectN || !portBEnable) |=> ($stable(portBDataOut) || $rose(b_q.outValid)))
        else $error("port B data changed without access");

    release_b_bus_a: assert property (@(posedge portBClock) disable iff (rstB)
        portBSelectN |-> portBDataOeN)
        else $error("port B bus driven while deselected");

    no_enable_b_a: assert property (@(posedge portBClock) disable iff (rstB)
        (!portBEnable && !portBSelectN) |=> ($stable(portBDataOut) || $rose(b_q.outValid)))
        else $error("port B transfer without enable");

    std_empty_b_a: assert property (@(posedge portBClock) disable iff (rstB)
        (modeStdB && readB && portBEmptyOutputReady) |=> $stable(portBDataOut))
        else $error("port B read while empty changed data");

    fall_through_select_ready_b_a: assert property (@(posedge portBClock) disable iff (rstB)
        (!modeStdB && !fwdEmpty && !portBEmptyOutputReady) |=> portBEmptyOutputReady)
        else $error("port B word not presented");

    std_full_b_a: assert property (@(posedge portBClock) disable iff (rstB)
        (modeStdB && portBFullInputReady && writeB) |=> $stable(returnQueue.wr_q.bin))
        else $error("port B write taken while full");

    fall_through_select_space_b_a: assert property (@(posedge portBClock) disable iff (rstB)
        (!modeStdB && !portBFullInputReady && writeB) |=> $stable(returnQueue.wr_q.bin))
        else $error("port B write taken while not ready");

    fall_through_select_hold_b_a: assert property (@(posedge portBClock) disable iff (rstB)
        (!modeStdB && portBEmptyOutputReady && !readB) |=> portBEmptyOutputReady && $stable(portBDataOut))
        else $error("port B presented word lost without read");

    fall_through_select_hold_a_a: assert property (@(posedge clk) disable iff (rst)
        (!a_q.modeStd && portAEmptyOutputReady && !readA) |=> portAEmptyOutputReady && $stable(portADataOut))
        else $error("port A presented word lost without read");
endmodule

// >>> pkg/bfpcf_pkg.sv
// Shared constants for the bidirectional queue port control block
package bfpcf_pkg;
    // Data width of each port bus
    localparam int PORT_WIDTH = 36;
    // Address bits of each queue, 2048 words
    localparam int QUEUE_ADDR_BITS = 11;
    // Level of the timing select pin that picks standard timing
    localparam logic MODE_STD_LEVEL = 1'h1;
    // Output register value after reset
    localparam logic [PORT_WIDTH-1:0] DATA_RESET = 36'h000000000;
    // Queue empty indication after reset
    localparam logic EMPTY_RESET = 1'h1;
    // Queue full indication after reset
    localparam logic FULL_RESET = 1'h0;
    // Output-ready state after reset
    localparam logic VALID_RESET = 1'h0;
endpackage

// >>> design/bfpcf_async_queue.sv
// Dual-clock queue with gray-coded pointers and registered full/empty
`timescale 1ns/1ps
module bfpcf_async_queue
    import bfpcf_pkg::*;
#(
    parameter int WIDTH = PORT_WIDTH,
    parameter int ADDR_BITS = QUEUE_ADDR_BITS
) (
    input wire logic wrClk,
    input wire logic wrRst,
    input wire logic wrPush,
    input wire logic [WIDTH-1:0] wrData,
    output logic wrFull,
    input wire logic rdClk,
    input wire logic rdRst,
    input wire logic rdPop,
    output logic [WIDTH-1:0] rdData,
    output logic rdEmpty
);
    // Pointer state of one side
    typedef struct packed {
        logic [ADDR_BITS:0] bin;
        logic [ADDR_BITS:0] gray;
        logic [ADDR_BITS:0] peerSync1;
        logic [ADDR_BITS:0] peerSync2;
        logic flag;
    } bfpcf_ptr_type;

    // Write side and read side state
    bfpcf_ptr_type wr_q, wr_d, rd_q, rd_d;
    // Word storage
    logic [WIDTH-1:0] mem [0:(1<<ADDR_BITS)-1];

    // Binary to gray conversion
    function automatic logic [ADDR_BITS:0] toGray(input logic [ADDR_BITS:0] b);
        toGray = b ^ (b >> 1);
    endfunction

    // Write pointer and full flag, write clock only
    always_comb begin
        wr_d = wr_q;
        wr_d.peerSync1 = rd_q.gray;
        wr_d.peerSync2 = wr_q.peerSync1;
        // Push ignored while full
        if (wrPush && !wr_q.flag) begin
            wr_d.bin = wr_q.bin + 1'h1;
        end
        wr_d.gray = toGray(wr_d.bin);
        wr_d.flag = (wr_d.gray == {~wr_q.peerSync2[ADDR_BITS:ADDR_BITS-1],
                                   wr_q.peerSync2[ADDR_BITS-2:0]});
        // Synchronous reset
        if (wrRst) begin
            wr_d = '0;
            wr_d.flag = FULL_RESET;
        end
    end

    // Register write side
    always_ff @(posedge wrClk) begin
        wr_q <= wr_d;
    end

    // Storage write
    always_ff @(posedge wrClk) begin
        if (wrPush && !wr_q.flag) begin
            mem[wr_q.bin[ADDR_BITS-1:0]] <= wrData;
        end
    end

    // Read pointer and empty flag, read clock only
    always_comb begin
        rd_d = rd_q;
        rd_d.peerSync1 = wr_q.gray;
        rd_d.peerSync2 = rd_q.peerSync1;
        // Pop ignored while empty
        if (rdPop && !rd_q.flag) begin
            rd_d.bin = rd_q.bin + 1'h1;
        end
        rd_d.gray = toGray(rd_d.bin);
        rd_d.flag = (rd_d.gray == rd_q.peerSync2);
        // Synchronous reset
        if (rdRst) begin
            rd_d = '0;
            rd_d.flag = EMPTY_RESET;
        end
    end

    // Register read side
    always_ff @(posedge rdClk) begin
        rd_q <= rd_d;
    end

    // Head word and flags
    assign rdData = mem[rd_q.bin[ADDR_BITS-1:0]];
    assign rdEmpty = rd_q.flag;
    assign wrFull = wr_q.flag;
endmodule

// >>> verification/bfpcf_port_b_host.sv
// Port B host model: single accesses timed by the port B clock
`timescale 1ns/1ps
module bfpcf_port_b_host
    import bfpcf_pkg::*;
(
    input wire logic portBClock,
    output logic portBSelectN,
    output logic portBEnable,
    output logic portBWrite,
    output logic [PORT_WIDTH-1:0] portBDataIn
);
    // Idle bus at time zero
    initial begin
        portBSelectN = 1'h1;
        portBEnable = 1'h0;
        portBWrite = 1'h0;
        portBDataIn = 36'h0;
    end
    // One edge with the given select and enable
    task automatic access(input logic sn, input logic en, input logic wr,
                          input logic [PORT_WIDTH-1:0] d, input int stall);
        repeat (stall + 1) @(posedge portBClock);
        portBSelectN <= sn;
        portBEnable <= en;
        portBWrite <= wr;
        portBDataIn <= d;
        @(posedge portBClock);
        portBSelectN <= 1'h1;
        portBEnable <= 1'h0;
        // Released bus shows the inverse of the last word
        portBDataIn <= ~d;
    endtask
endmodule

// >>> verification/testbench.sv
// Self-checking bench for the port control block in both timing modes
`timescale 1ns/1ps
module testbench;
    import bfpcf_pkg::*;
    // Small queues keep the fills short
    localparam int ADDR_BITS = 3;
    localparam int DEPTH = 8;
    logic clk = 1'h0;
    logic portBClock = 1'h0;
    logic rst = 1'h1;
    logic fallThroughSelect = 1'h1;
    logic portASelectN = 1'h1;
    logic portAEnable = 1'h0;
    logic portAWrite = 1'h0;
    logic [PORT_WIDTH-1:0] portADataIn = 36'h0;
    logic [PORT_WIDTH-1:0] portADataOut, portBDataOut, portBDataIn;
    logic portADataOeN, portAFullInputReady, portAEmptyOutputReady;
    logic portBSelectN, portBEnable, portBWrite, portBDataOeN, portBFullInputReady, portBEmptyOutputReady;
    logic [1:0] aFlags, bFlags; // Flags just after own edge
    logic [PORT_WIDTH-1:0] fwdQ[$], retQ[$]; // Expected words
    int err_total = 0;
    int num_checks = 0;
    int seed = 55219;
    int n;
    logic std; // Timing select level of this phase
    // Port A clock, 40 ns
    always #20 clk = ~clk;
    // Port B clock, 32 ns, shifted phase
    always begin
        if ($time == 0) #7;
        #16 portBClock = ~portBClock;
    end
    bfpcf_port_control #(.ADDR_BITS(ADDR_BITS)) bfpcf_port_control_inst (.clk(clk), .rst(rst),
        .portBClock(portBClock), .fallThroughSelect(fallThroughSelect), .portASelectN(portASelectN),
        .portAEnable(portAEnable), .portAWrite(portAWrite), .portADataIn(portADataIn),
        .portADataOut(portADataOut), .portADataOeN(portADataOeN), .portAFullInputReady(portAFullInputReady),
        .portAEmptyOutputReady(portAEmptyOutputReady), .portBSelectN(portBSelectN), .portBEnable(portBEnable),
        .portBWrite(portBWrite), .portBDataIn(portBDataIn), .portBDataOut(portBDataOut),
        .portBDataOeN(portBDataOeN), .portBFullInputReady(portBFullInputReady),
        .portBEmptyOutputReady(portBEmptyOutputReady));
    bfpcf_port_b_host bfpcf_port_b_host_inst (.portBClock(portBClock), .portBSelectN(portBSelectN),
        .portBEnable(portBEnable), .portBWrite(portBWrite), .portBDataIn(portBDataIn));
    // Compare and count
    task automatic check(input logic [PORT_WIDTH-1:0] seen, input logic [PORT_WIDTH-1:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Flag level for a full or empty condition in this mode
    function automatic logic flagFor(input logic s, input logic c);
        return (s === MODE_STD_LEVEL) ? c : ~c;
    endfunction
    function automatic logic [PORT_WIDTH-1:0] randWord();
        return PORT_WIDTH'({$random(seed), $random(seed)});
    endfunction
    function automatic logic sigSel(input int idx);
        case (idx)
            0: return portAFullInputReady;
            1: return portAEmptyOutputReady;
            2: return portBFullInputReady;
            default: return portBEmptyOutputReady;
        endcase
    endfunction
    // Bounded wait for a flag level
    task automatic waitCond(input int idx, input logic want);
        int k;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (k < 300 && sigSel(idx) !== want);
        if (sigSel(idx) !== want) begin
            err_total++;
            $display("Error at %0t: flag wait ran out", $time);
            end_sim();
        end
    endtask
    // One port A edge with given select and enable
    task automatic accA(input logic sn, input logic en, input logic wr, input logic [PORT_WIDTH-1:0] d);
        @(posedge clk);
        portASelectN <= sn;
        portAEnable <= en;
        portAWrite <= wr;
        portADataIn <= d;
        @(posedge clk);
        portASelectN <= 1'h1;
        portAEnable <= 1'h0;
        portADataIn <= ~d;
    endtask
    task automatic writeA(input logic [PORT_WIDTH-1:0] d);
        waitCond(0, flagFor(std, 1'h0));
        accA(1'h0, 1'h1, 1'h1, d);
        fwdQ.push_back(d);
    endtask
    task automatic writeB(input logic [PORT_WIDTH-1:0] d);
        waitCond(2, flagFor(std, 1'h0));
        bfpcf_port_b_host_inst.access(1'h0, 1'h1, 1'h1, d, $unsigned($random(seed)) % 3);
        retQ.push_back(d);
    endtask
    task automatic readA();
        logic [PORT_WIDTH-1:0] exp;
        exp = retQ.pop_front();
        waitCond(1, flagFor(std, 1'h0));
        if (std !== MODE_STD_LEVEL) check(portADataOut, exp);
        accA(1'h0, 1'h1, 1'h0, randWord());
        #1;
        if (std === MODE_STD_LEVEL) check(portADataOut, exp);
    endtask
    task automatic readB();
        logic [PORT_WIDTH-1:0] exp;
        exp = fwdQ.pop_front();
        waitCond(3, flagFor(std, 1'h0));
        if (std !== MODE_STD_LEVEL) check(portBDataOut, exp);
        bfpcf_port_b_host_inst.access(1'h0, 1'h1, 1'h0, randWord(), $unsigned($random(seed)) % 3);
        #1;
        if (std === MODE_STD_LEVEL) check(portBDataOut, exp);
    endtask
    // Flags captured just after each edge, compared mid-cycle
    always @(posedge clk) #1 aFlags = {portAFullInputReady, portAEmptyOutputReady};
    always @(posedge portBClock) #1 bFlags = {portBFullInputReady, portBEmptyOutputReady};
    always @(negedge clk) begin
        check(PORT_WIDTH'({portAFullInputReady, portAEmptyOutputReady}), PORT_WIDTH'(aFlags));
        check(PORT_WIDTH'(portADataOeN), PORT_WIDTH'(portASelectN));
    end
    always @(negedge portBClock) begin
        check(PORT_WIDTH'({portBFullInputReady, portBEmptyOutputReady}), PORT_WIDTH'(bFlags));
        check(PORT_WIDTH'(portBDataOeN), PORT_WIDTH'(portBSelectN));
    end
    // Main sequence: standard phase, then fall-through phase
    initial begin
        for (int m = 0; m < 2; m++) begin
            std = (m == 0) ? MODE_STD_LEVEL : ~MODE_STD_LEVEL;
            // Mid-run reset is raised on a port A edge
            if (m > 0) @(posedge clk);
            rst <= 1'h1;
            fallThroughSelect <= std;
            fwdQ.delete();
            retQ.delete();
            repeat (6) @(posedge clk);
            rst <= 1'h0;
            repeat (4) @(posedge portBClock);
            // Look once the edge has settled
            #1;
            check(PORT_WIDTH'(portAFullInputReady), PORT_WIDTH'(flagFor(std, 1'h0)));
            check(PORT_WIDTH'(portBEmptyOutputReady), PORT_WIDTH'(flagFor(std, 1'h1)));
            check(portBDataOut, DATA_RESET);
            // Accesses with select high or enable low move nothing
            accA(1'h1, 1'h1, 1'h1, randWord());
            accA(1'h0, 1'h0, 1'h1, randWord());
            bfpcf_port_b_host_inst.access(1'h1, 1'h1, 1'h1, randWord(), 0);
            bfpcf_port_b_host_inst.access(1'h0, 1'h0, 1'h1, randWord(), 1);
            // Forward fill until refused, one extra write, drain
            n = 0;
            while (n < DEPTH + 3 && portAFullInputReady === flagFor(std, 1'h0)) begin
                writeA(randWord());
                n++;
                repeat (4) @(posedge clk);
            end
            check(PORT_WIDTH'(n), PORT_WIDTH'(DEPTH + (m == 1)));
            accA(1'h0, 1'h1, 1'h1, randWord());
            repeat (n) readB();
            repeat (6) @(posedge portBClock);
            check(PORT_WIDTH'(portBEmptyOutputReady), PORT_WIDTH'(flagFor(std, 1'h1)));
            // Return fill from port B, drain at port A
            n = 0;
            while (n < DEPTH + 3 && portBFullInputReady === flagFor(std, 1'h0)) begin
                writeB(randWord());
                n++;
                repeat (4) @(posedge portBClock);
            end
            check(PORT_WIDTH'(n), PORT_WIDTH'(DEPTH + (m == 1)));
            bfpcf_port_b_host_inst.access(1'h0, 1'h1, 1'h1, randWord(), 1);
            repeat (n) readA();
            repeat (6) @(posedge clk);
            check(PORT_WIDTH'(portAEmptyOutputReady), PORT_WIDTH'(flagFor(std, 1'h1)));
            // Random mixed traffic both ways
            for (int i = 0; i < 80; i++) begin
                case ($unsigned($random(seed)) % 4)
                    0: if (fwdQ.size() < DEPTH - 1) writeA(randWord());
                    1: if (retQ.size() < DEPTH - 1) writeB(randWord());
                    2: if (fwdQ.size() > 0) readB();
                    default: if (retQ.size() > 0) readA();
                endcase
            end
        end
        end_sim();
    end
endmodule
